// ### hw/scg_clock_unit.sv
// How it works
// RQ1: In host mode the system reference clock input is the primary reference.
// RQ2: In agent mode the incoming PCI bus clock is the primary reference instead.
// RQ3: In host mode the reference feeds a divide-by-two and the PCI sync and clock output muxes.
// RQ4: The clock input strap picks whether PCI sync out is the reference undivided or halved.
// RQ5: Each PCI clock output carries PCI sync out only while its enable bit is set.
// RQ6: The system bus to PCI sync ratio is one plus the inverted strap, times the PLL factor.
// RQ7: The system PLL factor is only two through six, from the latched configuration word.
// RQ8: The core PLL ratio comes from the core PLL field and multiplies the system bus clock.
// RQ9: Both PLL fields come from the low configuration word or a hard-coded option at reset.
// RQ10: The memory clock is the system bus clock times one plus its doubling bit, halved out.
// RQ11: The local bus clock is the system bus clock times one plus its doubling bit.
// RQ12: The local bus clock outputs are the local bus clock divided by two, four or eight.
// RQ13: Unit clocks start at full rate; software picks off, full, half or third, PCI/DMA off or full.
// RQ14: Software and straps must keep every clock within its frequency limit.
// RQ15: Memory data move at twice the external memory bus clock, the memory controller rate.
// RQ16: The PLL factor is four bits, codes 2 to 6 valid, the rest reserved.
// RQ17: Unit ratio changes and shut-offs take effect without runt pulses.
`timescale 1ns/1ps
`default_nettype none
module scg_clock_unit
    import scg_pkg::*;
#(
    parameter int NUM_PCI_OUT = 5
) (
    input wire logic SYS_CLK,                                    // 250 MHz system clock.
    input wire logic RESET,                                      // Synchronous reset, active high.
    input wire logic PCI_HOST_MODE,                              // Strap: host when high.
    input wire logic CLOCK_INPUT_HALVE_STRAP,                    // Strap: high passes undivided.
    input wire logic HARD_CODED_RESET,                           // Use the hard-coded word.
    input wire scg_pkg::scg_rcw_t RESET_CONFIG_WORD_LOW,         // Configuration word at reset.
    input wire logic SYSTEM_REF_CLOCK_IN,                        // Reference clock tick (host).
    input wire logic PCI_CLK_IN,                                 // PCI bus clock tick (agent).
    input wire logic PLL_VCO_TICK,                               // System PLL output tick.
    input wire logic [NUM_PCI_OUT-1:0] PCI_CLOCK_OUT_ENABLE_N,   // Output clock control bits.
    input wire scg_pkg::scg_local_bus_clock_ratio_reg_t LOCAL_BUS_CLOCK_RATIO_REG,    // Local bus divider.
    input wire scg_pkg::scg_system_clock_control_reg_t SYSTEM_CLOCK_CONTROL_REG,     // Unit clock ratios.
    output logic PCI_SYNC_OUT,                                   // PCI sync tick.
    output logic [NUM_PCI_OUT-1:0] PCI_CLOCK_OUT_N,              // PCI clock output ticks.
    output logic [3:0] CSB_INPUT_RATIO,                          // csb to sync-in ratio.
    output logic SYSTEM_PLL_FACTOR_VALID,                                     // PLL factor is legal.
    output logic [6:0] CORE_PLL_RATIO,                           // Core PLL ratio code.
    output logic CORE_PLL_BYPASS,                                // Core runs on csb clock.
    output logic CSB_CLK_TICK,                                   // System bus clock tick.
    output logic MEM_DATA_TICK,                                  // Memory data beat tick.
    output logic [1:0] MEMORY_BUS_CLOCK_PAIR,                    // Memory clock, true/compl.
    output logic LBC_CLK_TICK,                                   // Internal local bus tick.
    output logic [1:0] LOCAL_BUS_CLOCK_OUTS,                     // External local bus clocks.
    output logic [SCG_NUM_UNITS-1:0] UNIT_CLK_TICK               // Per-unit clock ticks.
);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration captured while reset is held; it cannot change afterwards.
    scg_rcw_t rcw;
    logic host;
    logic undivided;
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rcw <= HARD_CODED_RESET ? SCG_HARD_RCW : RESET_CONFIG_WORD_LOW; // RQ9
            host <= PCI_HOST_MODE;
            undivided <= CLOCK_INPUT_HALVE_STRAP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Primary reference selection and the divide-by-two in front of the sync mux.
    logic half_phase;
    logic ref_half_tick;
    logic sync_tick;
    assign ref_half_tick = SYSTEM_REF_CLOCK_IN && half_phase; // RQ3
    assign sync_tick = host ? (undivided ? SYSTEM_REF_CLOCK_IN : ref_half_tick) // RQ1 RQ4
                            : PCI_CLK_IN; // RQ2
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            half_phase <= 1'b0;
            PCI_SYNC_OUT <= 1'b0;
            PCI_CLOCK_OUT_N <= '0;
        end else begin
            if (SYSTEM_REF_CLOCK_IN) begin
                half_phase <= !half_phase; // RQ3
            end
            PCI_SYNC_OUT <= sync_tick;
            PCI_CLOCK_OUT_N <= {NUM_PCI_OUT{sync_tick}} & PCI_CLOCK_OUT_ENABLE_N; // RQ5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Multiplier reporting; a reserved PLL code reports a ratio of zero.
    logic system_pll_factor_ok;
    logic [3:0] pre_mult;
    logic [3:0] next_ratio;
    assign system_pll_factor_ok = rcw.system_pll_factor >= SCG_SYSTEM_PLL_FACTOR_MIN &&
                     rcw.system_pll_factor <= SCG_SYSTEM_PLL_FACTOR_MAX; // RQ7 RQ16
    assign pre_mult = undivided ? 4'h1 : 4'h2;
    assign next_ratio = system_pll_factor_ok ? 4'(pre_mult * rcw.system_pll_factor) : 4'h0; // RQ6
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            CSB_INPUT_RATIO <= 4'h0;
            SYSTEM_PLL_FACTOR_VALID <= 1'b0;
            CORE_PLL_RATIO <= 7'h00;
            CORE_PLL_BYPASS <= 1'b1;
        end else begin
            CSB_INPUT_RATIO <= next_ratio; // RQ6
            SYSTEM_PLL_FACTOR_VALID <= system_pll_factor_ok; // RQ16
            CORE_PLL_RATIO <= rcw.core_pll_ratio; // RQ8
            CORE_PLL_BYPASS <= rcw.core_pll_ratio[4:1] == SCG_CORE_BYPASS_CODE; // RQ8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The PLL runs at twice csb when either doubling bit is set, so csb is its half.
    logic doubling;
    logic csb_phase;
    logic csb_tick;
    logic ddr_tick;
    logic lbc_tick;
    assign doubling = rcw.memory_clock_doubling_bit || rcw.local_bus_clock_doubling_bit;
    assign csb_tick = doubling ? (PLL_VCO_TICK && csb_phase) : PLL_VCO_TICK;
    assign ddr_tick = rcw.memory_clock_doubling_bit ? PLL_VCO_TICK : csb_tick; // RQ10
    assign lbc_tick = rcw.local_bus_clock_doubling_bit ? PLL_VCO_TICK : csb_tick; // RQ11

    ////////////////////////////////////////////////////////////////////////////
    // Memory clock pair toggles on each ddr tick; data beat on every ddr tick.
    logic memory_bus_clock_pair;
    logic [2:0] lb_cnt;
    logic lclk_sel;
    logic [1:0] lb_div;
    // Divider code 3 has no meaning of its own, so it falls through to the slowest rate.
    assign lb_div = LOCAL_BUS_CLOCK_RATIO_REG.local_bus_divider_field;
    assign lclk_sel = (lb_div == SCG_LB_DIV2) ? lb_cnt[0] :
                      (lb_div == SCG_LB_DIV4) ? lb_cnt[1] :
                      lb_cnt[2]; // RQ12
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            csb_phase <= 1'b0;
            memory_bus_clock_pair <= 1'b0;
            lb_cnt <= 3'h0;
            CSB_CLK_TICK <= 1'b0;
            MEM_DATA_TICK <= 1'b0;
            LBC_CLK_TICK <= 1'b0;
        end else begin
            if (PLL_VCO_TICK) begin
                csb_phase <= !csb_phase;
            end
            if (ddr_tick) begin
                memory_bus_clock_pair <= !memory_bus_clock_pair; // RQ10
            end
            if (lbc_tick) begin
                lb_cnt <= lb_cnt + 3'h1; // RQ12
            end
            CSB_CLK_TICK <= csb_tick;
            MEM_DATA_TICK <= ddr_tick; // RQ15
            LBC_CLK_TICK <= lbc_tick; // RQ11
        end
    end
    assign MEMORY_BUS_CLOCK_PAIR = {!memory_bus_clock_pair, memory_bus_clock_pair}; // RQ10
    assign LOCAL_BUS_CLOCK_OUTS = {2{lclk_sel}}; // RQ12

    ////////////////////////////////////////////////////////////////////////////
    // One glitch-free ratio gate per configurable unit; PCI/DMA limited to off or full.
    scg_ratio_t ratio_req [SCG_NUM_UNITS];
    assign ratio_req[0] = SYSTEM_CLOCK_CONTROL_REG.ethernet_unit_one;
    assign ratio_req[1] = SYSTEM_CLOCK_CONTROL_REG.ethernet_unit_two;
    assign ratio_req[2] = SYSTEM_CLOCK_CONTROL_REG.security_clock_ratio;
    assign ratio_req[3] = SYSTEM_CLOCK_CONTROL_REG.usb_clock_ratio;
    assign ratio_req[4] = SYSTEM_CLOCK_CONTROL_REG.pci_dma;
    generate
        for (genvar u = 0; u < SCG_NUM_UNITS; u++) begin : g_unit
            scg_unit_clock_gate #(
                .FULL_ONLY(u == SCG_PCI_UNIT)
            ) u_gate (
                .clk(SYS_CLK),
                .rst(RESET),
                .csb_tick(csb_tick),
                .ratio_req(ratio_req[u]),
                .unit_tick(UNIT_CLK_TICK[u]), // RQ13 RQ17
                .ratio_now()
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_host_ref_pick: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ1
        (host && undivided) |-> ##1 (PCI_SYNC_OUT == $past(SYSTEM_REF_CLOCK_IN)))
        else $error("Host sync out does not follow the reference.");
    a_agent_ref_pick: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ2
        !host |-> ##1 (PCI_SYNC_OUT == $past(PCI_CLK_IN)))
        else $error("Agent sync out does not follow the PCI clock.");
    a_halved_sync: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ3 RQ4
        (host && !undivided && PCI_SYNC_OUT) |-> $past(half_phase) && $past(SYSTEM_REF_CLOCK_IN))
        else $error("Halved sync out ticked on the wrong phase.");
    a_pci_out_gate: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ5
        ##1 PCI_CLOCK_OUT_N == ({NUM_PCI_OUT{PCI_SYNC_OUT}} & $past(PCI_CLOCK_OUT_ENABLE_N)))
        else $error("PCI clock output ignores its enable.");
    a_ratio_value: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ6 RQ7
        ##1 CSB_INPUT_RATIO == (SYSTEM_PLL_FACTOR_VALID ? 4'(pre_mult * rcw.system_pll_factor) : 4'h0))
        else $error("System bus ratio wrong.");
    a_system_pll_factor_range: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ16
        ##1 SYSTEM_PLL_FACTOR_VALID |-> (CSB_INPUT_RATIO >= 4'h2 && CSB_INPUT_RATIO <= 4'hc))
        else $error("Valid PLL factor gives out-of-range ratio.");
    a_mck_pair: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ10
        $past(ddr_tick) |-> MEMORY_BUS_CLOCK_PAIR != $past(MEMORY_BUS_CLOCK_PAIR))
        else $error("Memory clock missed a ddr tick.");
    a_mem_beat: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ15
        (rcw.memory_clock_doubling_bit && PLL_VCO_TICK) |=> MEM_DATA_TICK)
        else $error("Doubled memory clock missed a beat.");
    a_lb_double: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ11
        (!rcw.local_bus_clock_doubling_bit) |=> LBC_CLK_TICK == CSB_CLK_TICK)
        else $error("Undoubled local bus clock departs from csb.");
    // The local bus pins must always agree and the memory pins always differ; these checks are disabled while reset holds the counters.
    a_mck_complement: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ10
        MEMORY_BUS_CLOCK_PAIR[1] != MEMORY_BUS_CLOCK_PAIR[0])
        else $error("Memory clock pair is not complementary.");
    a_lclk_pins_agree: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ12
        LOCAL_BUS_CLOCK_OUTS[1] == LOCAL_BUS_CLOCK_OUTS[0])
        else $error("Local bus clock outputs disagree.");
    a_bypass_code: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ8
        CORE_PLL_BYPASS == (CORE_PLL_RATIO[4:1] == 4'h0))
        else $error("Core bypass flag does not match the core ratio code.");
    c_csb_halved: cover property (@(posedge SYS_CLK) doubling && CSB_CLK_TICK);
    c_host_halved: cover property (@(posedge SYS_CLK) host && !undivided ##1 PCI_SYNC_OUT);
    c_agent: cover property (@(posedge SYS_CLK) !host ##1 PCI_SYNC_OUT);
    c_lclk_div8: cover property (@(posedge SYS_CLK)
        LOCAL_BUS_CLOCK_RATIO_REG.local_bus_divider_field == SCG_LB_DIV8 && lb_cnt == 3'h7);

endmodule // scg_clock_unit
`default_nettype wire

// ### hw/scg_pkg.sv
package scg_pkg;

    // Reset configuration word low, as the device latches it.
    typedef struct packed {
        logic local_bus_clock_doubling_bit; // Local bus clock at twice the system bus clock.
        logic memory_clock_doubling_bit;    // Memory controller clock at twice the system bus clock.
        logic [3:0] system_pll_factor;      // System PLL multiplication code.
        logic [6:0] core_pll_ratio;         // Core PLL ratio code, passed to the core PLL.
    } scg_rcw_t;

    // Unit clock ratio codes.
    typedef enum logic [1:0] {
        SCG_RATIO_OFF = 2'h0,
        SCG_RATIO_FULL = 2'h1,
        SCG_RATIO_HALF = 2'h2,
        SCG_RATIO_THIRD = 2'h3
    } scg_ratio_t;

    // System clock control register: one ratio per configurable unit.
    typedef struct packed {
        scg_ratio_t pci_dma;           // Off or full only.
        scg_ratio_t usb_clock_ratio;
        scg_ratio_t security_clock_ratio;
        scg_ratio_t ethernet_unit_two;
        scg_ratio_t ethernet_unit_one;
    } scg_system_clock_control_reg_t;

    // Local bus clock ratio register.
    typedef struct packed {
        logic [1:0] local_bus_divider_field;
    } scg_local_bus_clock_ratio_reg_t;

    localparam int SCG_NUM_UNITS = 5;
    localparam int SCG_PCI_UNIT = 4;
    localparam logic [3:0] SCG_SYSTEM_PLL_FACTOR_MIN = 4'h2;
    localparam logic [3:0] SCG_SYSTEM_PLL_FACTOR_MAX = 4'h6;
    localparam logic [3:0] SCG_CORE_BYPASS_CODE = 4'h0;
    localparam logic [1:0] SCG_LB_DIV2 = 2'h0;
    localparam logic [1:0] SCG_LB_DIV4 = 2'h1;
    localparam logic [1:0] SCG_LB_DIV8 = 2'h2;
    localparam logic [1:0] SCG_THIRD_LAST = 2'h2;
    localparam logic [1:0] SCG_HALF_LAST = 2'h1;
    // Hard-coded reset option: x4 system PLL, core PLL bypassed (arbitrary choice).
    localparam scg_rcw_t SCG_HARD_RCW = '{1'b0, 1'b0, 4'h4, 7'h00};

endpackage

// ### hw/scg_unit_clock_gate.sv
`timescale 1ns/1ps
`default_nettype none
module scg_unit_clock_gate
    import scg_pkg::*;
#(
    parameter bit FULL_ONLY = 1'b0
) (
    input wire logic clk,                       // System clock.
    input wire logic rst,                       // Synchronous reset, active high.
    input wire logic csb_tick,                  // System bus clock tick.
    input wire scg_pkg::scg_ratio_t ratio_req,  // Requested ratio from software.
    output logic unit_tick,                     // Unit clock tick, registered.
    output scg_pkg::scg_ratio_t ratio_now       // Ratio in force.
);

    ////////////////////////////////////////////////////////////////////////////
    // A restricted unit treats the divided codes as full rate.
    scg_ratio_t req_legal;
    logic [1:0] last;
    logic period_end;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    assign req_legal = (FULL_ONLY && ratio_req != SCG_RATIO_OFF) ? SCG_RATIO_FULL : ratio_req;
    assign last = (ratio_now == SCG_RATIO_THIRD) ? SCG_THIRD_LAST :
                  (ratio_now == SCG_RATIO_HALF) ? SCG_HALF_LAST : 2'h0;
    assign period_end = csb_tick && (cnt == last);
    assign next_cnt = period_end ? 2'h0 : (cnt + 2'h1);

    ////////////////////////////////////////////////////////////////////////////
    // New ratios are taken at a period boundary, or at once while the unit is off, so no runt reaches the unit.
    always_ff @(posedge clk) begin
        if (rst) begin
            ratio_now <= SCG_RATIO_FULL; // RQ13
            cnt <= 2'h0;
            unit_tick <= 1'b0;
        end else begin
            if (period_end || ratio_now == SCG_RATIO_OFF) begin
                ratio_now <= req_legal; // RQ17
            end
            if (csb_tick) begin
                cnt <= next_cnt;
            end
            unit_tick <= csb_tick && cnt == 2'h0 && ratio_now != SCG_RATIO_OFF; // RQ13
        end
    end

    a_ratio_at_boundary: assert property (@(posedge clk) disable iff (rst) // RQ17
        ($past(ratio_now) != ratio_now && $past(ratio_now) != SCG_RATIO_OFF)
            |-> $past(period_end))
        else $error("Unit ratio changed in mid period.");
    a_off_silent: assert property (@(posedge clk) disable iff (rst) // RQ13
        ratio_now == SCG_RATIO_OFF |=> !unit_tick)
        else $error("Unit clock ticked while off.");
    a_half_spacing: assert property (@(posedge clk) disable iff (rst) // RQ13
        (ratio_now == SCG_RATIO_HALF && csb_tick && cnt == 2'h0 && !period_end)
            |=> ##[0:300] (csb_tick && $past(unit_tick)) |-> !unit_tick)
        else $error("Half rate unit ticked twice in a row.");
    c_goes_off: cover property (@(posedge clk) disable iff (rst)
        ratio_now == SCG_RATIO_FULL ##1 ratio_now == SCG_RATIO_OFF);

endmodule // scg_unit_clock_gate
`default_nettype wire

// ### testbench/scg_clock_source.sv
`timescale 1ns/1ps
`default_nettype none
// Board reference, PCI bus clock and PLL stand-in; each clock is a burst of one-cycle ticks.
module scg_clock_source (
    input wire logic clk,         // Bench clock.
    input wire logic rst,         // Synchronous reset, active high.
    input wire logic go,          // Starts a burst.
    input wire logic [7:0] ref_n, // Reference ticks per burst.
    input wire logic [7:0] pci_n, // PCI clock ticks per burst.
    input wire logic [7:0] vco_n, // PLL ticks per burst.
    output logic ref_tick,        // Board reference tick.
    output logic pci_tick,        // PCI bus clock tick.
    output logic vco_tick,        // PLL output tick.
    output logic busy             // Burst still running.
);
    int phase;
    logic [7:0] ref_left;
    logic [7:0] pci_left;
    logic [7:0] vco_left;
    // Rates of 1/6, 1/9 and 1/2 of the clock keep every derived clock under its ceiling.
    wire ref_now = (ref_left != 8'h00) && (phase % 6 == 5);
    wire pci_now = (pci_left != 8'h00) && (phase % 9 == 8);
    wire vco_now = (vco_left != 8'h00) && (phase % 2 == 1);
    assign busy = (ref_left != 8'h00) || (pci_left != 8'h00) || (vco_left != 8'h00);
    // Outside a burst every clock stands still, as a gated board source would.
    always_ff @(posedge clk) begin
        phase <= (rst || go) ? 0 : phase + 1;
        ref_left <= rst ? 8'h00 : go ? ref_n : ref_left - {7'h00, ref_now};
        pci_left <= rst ? 8'h00 : go ? pci_n : pci_left - {7'h00, pci_now};
        vco_left <= rst ? 8'h00 : go ? vco_n : vco_left - {7'h00, vco_now};
        ref_tick <= ref_now && !rst && !go;
        pci_tick <= pci_now && !rst && !go;
        vco_tick <= vco_now && !rst && !go;
    end
endmodule // scg_clock_source
`default_nettype wire

// ### testbench/scg_clock_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scg_clock_unit_tb;
    import scg_pkg::*;
    typedef struct packed {
        logic host;
        logic strap;
        logic hard;
        scg_rcw_t rcw;
        logic [1:0] local_bus_clock_ratio_reg;
        scg_system_clock_control_reg_t system_clock_control_reg;
        logic [4:0] en;
        logic [3:0] exp_ratio;
        logic exp_valid;
    } scg_tb_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic host = 1'b0;
    logic strap = 1'b0;
    logic hard = 1'b0;
    logic go = 1'b0;
    scg_rcw_t rcw = '0;
    logic [4:0] en = 5'h00;
    scg_local_bus_clock_ratio_reg_t local_bus_clock_ratio_reg = '0;
    scg_system_clock_control_reg_t system_clock_control_reg = '0;
    logic ref_t, pci_t, vco_t, busy, sync, valid, bypass, csb, mem, lbc, lbo0_q, mck_q;
    logic [4:0] pco;
    logic [4:0] unit;
    logic [3:0] ratio;
    logic [6:0] core;
    logic [1:0] memory_bus_clock_pair;
    logic [1:0] lbo;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int cnt[17] = '{default: 0};
    scg_tb_row_t r;
    // Ordinary cases: straps and word at reset, then the ratio and valid flag it should report.
    scg_tb_row_t rows[7] = '{
        '{1'b1, 1'b1, 1'b0, '{1'b0, 1'b0, 4'h2, 7'h02}, 2'h0, 10'h16c, 5'h15, 4'h2, 1'b1},
        '{1'b1, 1'b0, 1'b0, '{1'b0, 1'b1, 4'h6, 7'h00}, 2'h1, 10'h0c9, 5'h0a, 4'hc, 1'b1},
        '{1'b0, 1'b1, 1'b0, '{1'b1, 1'b0, 4'h3, 7'h44}, 2'h2, 10'h236, 5'h1f, 4'h3, 1'b1},
        '{1'b0, 1'b0, 1'b0, '{1'b1, 1'b1, 4'h7, 7'h1e}, 2'h3, 10'h393, 5'h00, 4'h0, 1'b0},
        '{1'b1, 1'b1, 1'b1, '{1'b1, 1'b1, 4'h1, 7'h7f}, 2'h0, 10'h155, 5'h11, 4'h4, 1'b1},
        '{1'b1, 1'b0, 1'b0, '{1'b0, 1'b0, 4'h5, 7'h02}, 2'h1, 10'h1ae, 5'h1f, 4'ha, 1'b1},
        '{1'b0, 1'b1, 1'b0, '{1'b0, 1'b0, 4'h0, 7'h10}, 2'h0, 10'h155, 5'h04, 4'h0, 1'b0}};

    always #2 clk = ~clk;

    scg_clock_source i_scg_clock_source (.clk(clk), .rst(rst), .go(go), .ref_n(8'd12),
        .pci_n(8'd8), .vco_n(8'd24), .ref_tick(ref_t), .pci_tick(pci_t), .vco_tick(vco_t),
        .busy(busy));

    scg_clock_unit i_scg_clock_unit (.SYS_CLK(clk), .RESET(rst), .PCI_HOST_MODE(host),
        .CLOCK_INPUT_HALVE_STRAP(strap), .HARD_CODED_RESET(hard),
        .RESET_CONFIG_WORD_LOW(rcw), .SYSTEM_REF_CLOCK_IN(ref_t), .PCI_CLK_IN(pci_t),
        .PLL_VCO_TICK(vco_t), .PCI_CLOCK_OUT_ENABLE_N(en), .LOCAL_BUS_CLOCK_RATIO_REG(local_bus_clock_ratio_reg),
        .SYSTEM_CLOCK_CONTROL_REG(system_clock_control_reg), .PCI_SYNC_OUT(sync), .PCI_CLOCK_OUT_N(pco),
        .CSB_INPUT_RATIO(ratio), .SYSTEM_PLL_FACTOR_VALID(valid), .CORE_PLL_RATIO(core),
        .CORE_PLL_BYPASS(bypass), .CSB_CLK_TICK(csb), .MEM_DATA_TICK(mem),
        .MEMORY_BUS_CLOCK_PAIR(memory_bus_clock_pair), .LBC_CLK_TICK(lbc), .LOCAL_BUS_CLOCK_OUTS(lbo),
        .UNIT_CLK_TICK(unit));

    // Tallies ticks and rising edges; slot 16 counts cycles where the pins disagree.
    always @(posedge clk) begin
        lbo0_q <= lbo[0];
        mck_q <= memory_bus_clock_pair[0];
        cnt[0] <= cnt[0] + int'(sync);
        for (int i = 0; i < 5; i++) begin
            cnt[1 + i] <= cnt[1 + i] + int'(pco[i]);
            cnt[11 + i] <= cnt[11 + i] + int'(unit[i]);
        end
        cnt[6] <= cnt[6] + int'(csb);
        cnt[7] <= cnt[7] + int'(mem);
        cnt[8] <= cnt[8] + int'(lbc);
        cnt[9] <= cnt[9] + int'(lbo[0] && !lbo0_q);
        cnt[10] <= cnt[10] + int'(memory_bus_clock_pair[0] && !mck_q);
        cnt[16] <= cnt[16] + int'((pco !== ({5{sync}} & en)) || (lbo[1] !== lbo[0]) ||
            (memory_bus_clock_pair[1] !== ~memory_bus_clock_pair[0]));
    end

    // A hang is cut short well past the longest expected run.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD at %0t: saw %0h, expected %0h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One burst of every clock, waited out under a bound.
    task automatic burst();
        int n;
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        while (busy === 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
    endtask

    task automatic start(input scg_tb_row_t t);
        scg_rcw_t w;
        w = t.hard ? SCG_HARD_RCW : t.rcw;
        @(posedge clk);
        rst <= 1'b1;
        host <= t.host;
        strap <= t.strap;
        hard <= t.hard;
        rcw <= t.rcw;
        en <= t.en;
        local_bus_clock_ratio_reg <= t.local_bus_clock_ratio_reg;
        system_clock_control_reg <= t.system_clock_control_reg;
        repeat (3) @(posedge clk);
        check(32'({sync, pco, csb, mem, lbc, unit}), 32'h0);
        check(32'(memory_bus_clock_pair), 32'h2);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(32'(ratio), 32'(t.exp_ratio));
        check(32'(valid), 32'(t.exp_valid));
        check(32'(core), 32'(w.core_pll_ratio));
        check(32'(bypass), 32'(w.core_pll_ratio[4:1] == 4'h0));
    endtask

    // The first burst settles ratio phases; only the second one is measured.
    task automatic measure(input scg_tb_row_t t);
        int base[17];
        int s, c, m, l, k;
        scg_rcw_t w;
        scg_ratio_t u;
        w = t.hard ? SCG_HARD_RCW : t.rcw;
        burst();
        base = cnt;
        burst();
        s = t.host ? (t.strap ? 12 : 6) : 8;
        c = (w.memory_clock_doubling_bit || w.local_bus_clock_doubling_bit) ? 12 : 24;
        m = c * (1 + int'(w.memory_clock_doubling_bit));
        l = c * (1 + int'(w.local_bus_clock_doubling_bit));
        k = (t.local_bus_clock_ratio_reg == SCG_LB_DIV2) ? 2 : (t.local_bus_clock_ratio_reg == SCG_LB_DIV4) ? 4 : 8;
        check(cnt[0] - base[0], s);
        check(cnt[6] - base[6], c);
        check(cnt[7] - base[7], m);
        check(cnt[10] - base[10], m / 2);
        check(cnt[8] - base[8], l);
        check(cnt[9] - base[9], l / k);
        check(cnt[16] - base[16], 0);
        for (int i = 0; i < 5; i++) begin
            check(cnt[1 + i] - base[1 + i], t.en[i] ? s : 0);
            u = scg_ratio_t'(t.system_clock_control_reg[2 * i +: 2]);
            k = (u == SCG_RATIO_OFF) ? 0 : (u == SCG_RATIO_FULL || i == SCG_PCI_UNIT) ? c :
                (u == SCG_RATIO_HALF) ? c / 2 : c / 3;
            check(cnt[11 + i] - base[11 + i], k);
        end
    endtask

    // Table first; then late strap and word changes, and unit clocks switched off and back.
    initial begin
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            start(rows[i]);
            measure(rows[i]);
        end
        r = rows[5];
        start(r);
        rcw <= rows[1].rcw;
        strap <= ~r.strap;
        hard <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(32'(ratio), 32'(r.exp_ratio));
        r.system_clock_control_reg = '0;
        system_clock_control_reg <= r.system_clock_control_reg;
        measure(r);
        r.system_clock_control_reg = 10'h3ff;
        system_clock_control_reg <= r.system_clock_control_reg;
        measure(r);
        conclude();
    end
endmodule // scg_clock_unit_tb
`default_nettype wire
